// ===== rx_stats_pkg.sv
// Package of offsets, field layouts and constants for the receive statistics and PCS identity bank
package rx_stats_pkg;

  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 16;
  localparam int          ERR_CNT_W       = 10;
  localparam int          DROP_CNT_W      = 32;
  localparam int          PCS_REG_W       = 16;

  // Memory map selectors on the register port
  localparam logic [3:0]  MAP_MAC         = 4'h1;
  localparam logic [3:0]  MAP_PCS         = 4'h2;

  // MAC map offsets
  localparam logic [15:0] OFS_MISALIGNED  = 16'h0050;
  localparam logic [15:0] OFS_OVERRUN     = 16'h0051;
  localparam logic [15:0] OFS_FILTERED    = 16'h0052;

  // PHY-PCS map offsets
  localparam logic [15:0] OFS_DEV_PKG_LO  = 16'h0005;
  localparam logic [15:0] OFS_DEV_PKG_HI  = 16'h0006;

  // Devices-in-package field positions
  localparam int          BIT_STD_REGS    = 0;
  localparam int          BIT_MEDIUM_SUB  = 1;
  localparam int          BIT_CODING_SUB  = 3;

  localparam logic [15:0] DEV_PKG_HI_VAL  = 16'h0000;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

endpackage : rx_stats_pkg

// ===== sat_clr_counter.sv
// Saturating counter with clear on read where a simultaneous event survives as one
`timescale 1ns/10ps
module sat_clr_counter #(
  parameter int W = 10
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         event_in,
  input  wire logic         clear_in,
  output logic [W-1:0]      count_q
);

  localparam logic [W-1:0] ONE     = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] ALL_ONE = {W{1'b1}};
  localparam logic [W-1:0] ZERO    = {W{1'b0}};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_q <= ZERO;
    end else if (clear_in) begin
      count_q <= event_in ? ONE : ZERO;
    end else if (event_in && count_q != ALL_ONE) begin
      count_q <= count_q + ONE;
    end
  end

endmodule : sat_clr_counter

// ===== rx_error_stats.sv
// Receive error statistics and PHY-PCS identity registers behind the register port
`timescale 1ns/10ps

// Function
// - Count frames dropped for non-byte length
// - Ten-bit counters saturate at all ones
// - Read returns count then clears it
// - Count frames aborted by buffer overflow
// - Overflow frames still count as received
// - Count address-filtered discards in 32 bits
// - Filter count includes mask, broadcast, multicast
// - Filter counter saturates, never wraps
// - Filtered frames still count as received
// - Every register transfer carries 32 bits
// - PCS map registers are 16 bits
// - PCS upper bytes read zero, unwritable
// - Devices register bit 3 reads one
// - Bit 1 one; bits 15:4, 2 zero
// - Devices register bit 0 reads one
// - Second devices register reads all zero
module rx_error_stats #(
  parameter int ERR_W  = rx_stats_pkg::ERR_CNT_W,
  parameter int DROP_W = rx_stats_pkg::DROP_CNT_W
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        misaligned_frame_drops,
  input  wire logic        rx_buffer_overrun_aborts,
  input  wire logic        filter_value_mask_miss,
  input  wire logic        broadcast_suppress_hit,
  input  wire logic        multicast_suppress_hit,
  input  wire logic        reg_rd_en,
  input  wire logic        reg_wr_en,
  input  wire logic [3:0]  reg_map,
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata_q,
  output logic             reg_rd_valid_q,
  output logic             reg_hit_q,
  output logic             rx_ok_credit
);

  // One code per mapped register; anything else decodes to none
  typedef enum {
    SEL_MISALIGNED,
    SEL_OVERRUN,
    SEL_FILTERED,
    SEL_DEV_PKG_LO,
    SEL_DEV_PKG_HI,
    SEL_NONE
  } reg_sel_e;

  logic [ERR_W-1:0]  misaligned_q;
  logic [ERR_W-1:0]  overrun_q;
  logic [DROP_W-1:0] filtered_q;
  logic              address_filter_discards;
  logic              clr_misaligned;
  logic              clr_overrun;
  logic              clr_filtered;
  logic [31:0]       rdata_d;
  logic              hit_d;
  reg_sel_e          acc_sel;
  wire logic [rx_stats_pkg::PCS_REG_W-1:0] dev_pkg_lo;

  function automatic logic sel(input logic [3:0] map, input logic [15:0] addr,
                               input logic [3:0] want_map, input logic [15:0] want_addr);
    sel = (map == want_map) && (addr == want_addr);
  endfunction : sel

  function automatic logic [31:0] pad_pcs(input logic [15:0] v);
    pad_pcs = {16'h0000, v};
  endfunction : pad_pcs

  // Single decode shared by the clear strobes, the read mux and the hit flag
  function automatic reg_sel_e decode(input logic [3:0] map, input logic [15:0] addr);
    decode = SEL_NONE;
    if (sel(map, addr, rx_stats_pkg::MAP_MAC, rx_stats_pkg::OFS_MISALIGNED)) begin
      decode = SEL_MISALIGNED;
    end else if (sel(map, addr, rx_stats_pkg::MAP_MAC, rx_stats_pkg::OFS_OVERRUN)) begin
      decode = SEL_OVERRUN;
    end else if (sel(map, addr, rx_stats_pkg::MAP_MAC, rx_stats_pkg::OFS_FILTERED)) begin
      decode = SEL_FILTERED;
    end else if (sel(map, addr, rx_stats_pkg::MAP_PCS, rx_stats_pkg::OFS_DEV_PKG_LO)) begin
      decode = SEL_DEV_PKG_LO;
    end else if (sel(map, addr, rx_stats_pkg::MAP_PCS, rx_stats_pkg::OFS_DEV_PKG_HI)) begin
      decode = SEL_DEV_PKG_HI;
    end
  endfunction : decode

  // Presence bits of the first devices-in-package word; all other bits read zero
  for (genvar b = 0; b < rx_stats_pkg::PCS_REG_W; b++) begin : g_dev_lo
    if (b == rx_stats_pkg::BIT_CODING_SUB) begin : g_coding
      assign dev_pkg_lo[b] = 1'b1;
    end else if (b == rx_stats_pkg::BIT_MEDIUM_SUB) begin : g_medium
      assign dev_pkg_lo[b] = 1'b1;
    end else if (b == rx_stats_pkg::BIT_STD_REGS) begin : g_std
      assign dev_pkg_lo[b] = 1'b1;
    end else begin : g_zero
      assign dev_pkg_lo[b] = 1'b0;
    end
  end

  // Any of the three filter rejections counts as one discard
  assign address_filter_discards = filter_value_mask_miss | broadcast_suppress_hit |
                                   multicast_suppress_hit;

  // Overflow and filtered frames are not withheld from the received-ok tally
  assign rx_ok_credit = rx_buffer_overrun_aborts | address_filter_discards;

  // Clearing follows a read only; writes never reach a counter
  assign acc_sel        = decode(reg_map, reg_addr);
  assign clr_misaligned = reg_rd_en && (acc_sel == SEL_MISALIGNED);
  assign clr_overrun    = reg_rd_en && (acc_sel == SEL_OVERRUN);
  assign clr_filtered   = reg_rd_en && (acc_sel == SEL_FILTERED);

  sat_clr_counter #(.W(ERR_W)) u_misaligned (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .event_in (misaligned_frame_drops),
    .clear_in (clr_misaligned),
    .count_q  (misaligned_q)
  );

  sat_clr_counter #(.W(ERR_W)) u_overrun (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .event_in (rx_buffer_overrun_aborts),
    .clear_in (clr_overrun),
    .count_q  (overrun_q)
  );

  sat_clr_counter #(.W(DROP_W)) u_filtered (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .event_in (address_filter_discards),
    .clear_in (clr_filtered),
    .count_q  (filtered_q)
  );

  // Read mux: value seen is the count before the clear takes effect
  always_comb begin
    rdata_d = rx_stats_pkg::READ_ZERO;
    hit_d   = 1'b1;
    unique case (acc_sel)
      SEL_MISALIGNED: begin
        rdata_d = 32'(misaligned_q);
      end
      SEL_OVERRUN: begin
        rdata_d = 32'(overrun_q);
      end
      SEL_FILTERED: begin
        rdata_d = 32'(filtered_q);
      end
      SEL_DEV_PKG_LO: begin
        rdata_d = pad_pcs(dev_pkg_lo);
      end
      SEL_DEV_PKG_HI: begin
        rdata_d = pad_pcs(rx_stats_pkg::DEV_PKG_HI_VAL);
      end
      SEL_NONE: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Answer strobe one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
    end
  end

  // Full 32-bit word captured on the read strobe and held until the next read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= rx_stats_pkg::READ_ZERO;
    end else if (reg_rd_en) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Hit flag reports decode of the last read or write; write data is
  // ignored on purpose since nothing in this bank is writable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_hit_q <= 1'b0;
    end else if (reg_rd_en || reg_wr_en) begin
      reg_hit_q <= hit_d;
    end
  end

endmodule : rx_error_stats

// ===== rx_stats_monitor.sv
// Checker of read answer timing, read data layout and the received-credit output
`timescale 1ns/10ps
module rx_stats_monitor (
  input logic        clk_sys,
  input logic        rst,
  input logic        rx_buffer_overrun_aborts,
  input logic        filter_value_mask_miss,
  input logic        broadcast_suppress_hit,
  input logic        multicast_suppress_hit,
  input logic        reg_rd_en,
  input logic [3:0]  reg_map,
  input logic [15:0] reg_addr,
  input logic [31:0] reg_rdata_q,
  input logic        reg_rd_valid_q,
  input logic        reg_hit_q,
  input logic        rx_ok_credit
);
  logic [3:0]  map_q;
  logic [15:0] adr_q;
  logic        pcs;
  always_ff @(posedge clk_sys) begin
    map_q <= reg_map;
    adr_q <= reg_addr;
  end
  assign pcs = reg_rd_valid_q && map_q == 4'h2;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_valid_after_rd: assert property (reg_rd_en |=> reg_rd_valid_q) else $error("no answer");
  a_no_spur_valid: assert property (!reg_rd_en |=> !reg_rd_valid_q) else $error("stray valid");
  a_pcs_upper_zero: assert property (pcs |-> reg_rdata_q[31:16] == 16'h0000)
    else $error("pcs upper bytes set");
  a_err_upper_zero: assert property (reg_rd_valid_q && map_q == 4'h1 &&
    adr_q inside {16'h0050, 16'h0051} |-> reg_rdata_q[31:10] == 22'h0) else $error("upper set");
  a_dev_lo_value: assert property (pcs && adr_q == 16'h0005 |-> reg_rdata_q == 32'h0000000B)
    else $error("devices lo wrong");
  a_dev_hi_zero: assert property (pcs && adr_q == 16'h0006 |-> reg_rdata_q == 32'h0)
    else $error("devices hi wrong");
  a_pcs_hit_set: assert property (pcs && adr_q inside {16'h0005, 16'h0006} |-> reg_hit_q)
    else $error("pcs miss");
  a_credit_or: assert property (rx_ok_credit == (rx_buffer_overrun_aborts |
    filter_value_mask_miss | broadcast_suppress_hit | multicast_suppress_hit)) else $error("credit");
  c_mac_read: cover property (reg_rd_valid_q && map_q == 4'h1);
  c_pcs_read: cover property (pcs);
  c_credit: cover property (rx_ok_credit);
endmodule : rx_stats_monitor
bind rx_error_stats rx_stats_monitor u_mon (
  .clk_sys                  (clk_sys),
  .rst                      (rst),
  .rx_buffer_overrun_aborts (rx_buffer_overrun_aborts),
  .filter_value_mask_miss   (filter_value_mask_miss),
  .broadcast_suppress_hit   (broadcast_suppress_hit),
  .multicast_suppress_hit   (multicast_suppress_hit),
  .reg_rd_en                (reg_rd_en),
  .reg_map                  (reg_map),
  .reg_addr                 (reg_addr),
  .reg_rdata_q              (reg_rdata_q),
  .reg_rd_valid_q           (reg_rd_valid_q),
  .reg_hit_q                (reg_hit_q),
  .rx_ok_credit             (rx_ok_credit)
);

// ===== reg_host.sv
// Host model issuing one-cycle register read and write strobes
`timescale 1ns/10ps
module reg_host (
  input  logic        clk_sys,
  output logic        reg_rd_en,
  output logic        reg_wr_en,
  output logic [3:0]  reg_map,
  output logic [15:0] reg_addr,
  output logic [31:0] reg_wdata
);
  initial {reg_rd_en, reg_wr_en, reg_map, reg_addr, reg_wdata} = '0;
  // Called just after a rising edge; every transfer is a full word
  task acc(input logic w, input logic [3:0] m, input logic [15:0] a, input logic [31:0] d);
    reg_rd_en <= !w;
    reg_wr_en <= w;
    reg_map   <= m;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk_sys);
  endtask : acc
endmodule : reg_host

// ===== rx_error_stats_tb.sv
// Testbench of the receive statistics and identity registers
`timescale 1ns/10ps
module rx_error_stats_tb;
  logic        clk_sys, rst, reg_rd_en, reg_wr_en, reg_rd_valid_q, reg_hit_q, rx_ok_credit;
  logic [4:0]  ev;
  logic [3:0]  reg_map;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, expv;
  logic [31:0] q[$];
  int          mismatches, n_checks, seed, n, t;
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  reg_host u_host (.clk_sys(clk_sys), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_map(reg_map), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  rx_error_stats u_dut (.clk_sys(clk_sys), .rst(rst), .misaligned_frame_drops(ev[0]),
    .rx_buffer_overrun_aborts(ev[1]), .filter_value_mask_miss(ev[2]),
    .broadcast_suppress_hit(ev[3]), .multicast_suppress_hit(ev[4]), .reg_rd_en(reg_rd_en),
    .reg_wr_en(reg_wr_en), .reg_map(reg_map), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rd_valid_q(reg_rd_valid_q), .reg_hit_q(reg_hit_q),
    .rx_ok_credit(rx_ok_credit));
  task rd(input logic [3:0] m, input logic [15:0] a, input logic [31:0] e);
    q.push_back(e);
    u_host.acc(1'b0, m, a, 32'h0);
  endtask : rd
  task pulses(input logic [4:0] s, input int k);
    repeat (k) begin
      @(posedge clk_sys);
      ev <= s;
    end
    @(posedge clk_sys);
    ev <= 5'h00;
  endtask : pulses
  task chk_hit(input logic e);
    @(negedge clk_sys);
    n_checks++;
    if (reg_hit_q !== e) begin
      mismatches++;
      $display("unexpected %0t hit %b expected %b", $time, reg_hit_q, e);
    end
    @(posedge clk_sys);
  endtask : chk_hit
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  always @(negedge clk_sys) if (reg_rd_valid_q === 1'b1) begin
    expv = (q.size() > 0) ? q.pop_front() : 32'hDEADBEEF;
    n_checks++;
    if (reg_rdata_q !== expv) begin
      mismatches++;
      $display("unexpected %0t rdata %h expected %h", $time, reg_rdata_q, expv);
    end
  end
  initial begin
    seed = 96396;
    mismatches = 0;
    n_checks = 0;
    rst = 1'b1;
    ev = 5'h00;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (t = 0; t < 3; t++) rd(4'h1, 16'h0050 + t[15:0], 32'h0);
    for (t = 0; t < 3; t++) begin
      n = 1 + $unsigned($random(seed)) % 20;
      pulses(5'h01 << t, n);
      rd(4'h1, 16'h0050 + t[15:0], 32'(n));
      rd(4'h1, 16'h0050 + t[15:0], 32'h0);
    end
    pulses(5'h08, 3);
    pulses(5'h10, 2);
    pulses(5'h1C, 1);
    rd(4'h1, 16'h0052, 32'h6);
    pulses(5'h02, 1030);
    rd(4'h1, 16'h0051, 32'h3FF);
    ev <= 5'h01;
    rd(4'h1, 16'h0050, 32'h0);
    ev <= 5'h00;
    rd(4'h1, 16'h0050, 32'h2);
    pulses(5'h01, 4);
    u_host.acc(1'b1, 4'h1, 16'h0050, $random(seed));
    rd(4'h1, 16'h0050, 32'h4);
    chk_hit(1'b1);
    // Reset in mid-run must clear a counter that holds events
    pulses(5'h01, 3);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(4'h1, 16'h0050, 32'h0);
    u_host.acc(1'b1, 4'h2, 16'h0005, $random(seed));
    rd(4'h2, 16'h0005, 32'h0000000B);
    rd(4'h2, 16'h0006, 32'h0);
    chk_hit(1'b1);
    rd(4'h2, 16'h0007, 32'h0);
    chk_hit(1'b0);
    repeat (3) @(posedge clk_sys);
    if (q.size() != 0) begin
      mismatches++;
      $display("unexpected %0t %0d reads never answered", $time, q.size());
    end
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule : rx_error_stats_tb
